// *** shared/timer_pkg.sv ***
// Constants for the reload timer with watchdog and output pin.
// Assumes a single 40 MHz clock, instruction cycle equal to one clock.
//
// Notes on behaviour
// [R1] Mode register is four write-only bits, reset zero: reload select plus clock source.
// [R2] Software loads the counter from the load digits; it then counts one per tick.
// [R3] Tick at count 8'hff overflows: reload from load digits, or wrap to zero.
// [R4] Each overflow sets the sticky overflow flag until software clear or reset.
// [R5] With watchdog enabled an overflow requests a whole-chip reset.
// [R6] Software reloads the counter often enough that the watchdog never fires.
// [R7] Output mode register picks toggle, force low, force high or PWM; reset drives pin low.
// [R8] Toggle inverts on overflow; force low and force high drive that level on overflow.
// [R9] Software picks force low only while pin is high, force high only while low.
// [R10] PWM mode gives a variable-duty pulse set by mode and load value.
// [R11] A mode register write takes effect two cycles later; load only afterwards.
// [R12] Output mode register is three read/write bits, reset to zero.
// [R13] Low load digit is written first; writing it alone leaves the counter unchanged.
// [R14] Writing the high load digit loads the full eight-bit value into the counter.
// [R15] Reset clears the low load digit; the high digit is held invalid.
// [R16] Reading the high count digit latches the low digit for a later read.
// [R17] Software reads the high count digit before the low one for a coherent value.
// [R18] Eight-bit counter; load and count digits share two indexes, separate storage.
package timer_pkg;
	// ------------------------------------------------------------
	// Register indexes, byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_IRQ_STAT = 6'h02;
	localparam logic [5:0] IDX_MODE_CLK = 6'h0d;
	localparam logic [5:0] IDX_DIG_LOW  = 6'h0e;
	localparam logic [5:0] IDX_DIG_HIGH = 6'h0f;
	localparam logic [5:0] IDX_OUT_MODE = 6'h14;
	localparam logic [5:0] IDX_WDOG     = 6'h20;
	localparam logic [5:0] IDX_IRQ_CLR  = 6'h30;
	localparam logic [5:0] IDX_IRQ_EN   = 6'h31;
	// ------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------
	localparam int         OVF_BIT      = 2;
	localparam int         WDOG_BIT     = 1;
	localparam int         RELOAD_BIT   = 3;
	localparam logic [3:0] MODE_CLK_RST = 4'h0;
	localparam logic [2:0] OUT_MODE_RST = 3'h0;
	localparam logic [3:0] DIG_LOW_RST  = 4'h0;
	localparam logic [7:0] COUNT_MAX    = 8'hff;
	localparam logic [2:0] CLK_EXT      = 3'h7;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_DECERR  = 2'h3;
	// ------------------------------------------------------------
	// Output modes.
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OUT_PORT   = 3'b000,
		OUT_TOGGLE = 3'b001,
		OUT_FORCE0 = 3'b010,
		OUT_FORCE1 = 3'b011,
		OUT_PWM    = 3'b100
	} out_mode_t;
endpackage

// *** src/tick_source.sv ***
// Input tick generator: prescaled clock or synchronised event pin.
// Assumes event_pin is asynchronous to aclk.
`timescale 1ns/1ps
module tick_source (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic [2:0] clk_sel,
	input  wire logic       event_pin,
	output logic            tick
);
	logic [10:0] div_q;
	logic [2:0]  evt_q;
	logic        pre_hit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 11'h000;
		end else if (ce) begin
			div_q <= div_q + 11'h001;
		end
	end

	// Two flops synchronise the pin; the third only serves the edge test.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_q <= 3'h0;
		end else if (ce) begin
			evt_q <= {evt_q[1:0], event_pin};
		end
	end

	// [R1] Divider select decode.
	always_comb begin
		case (clk_sel)
			3'h0:    pre_hit = &div_q[10:0];
			3'h1:    pre_hit = &div_q[8:0];
			3'h2:    pre_hit = &div_q[6:0];
			3'h3:    pre_hit = &div_q[4:0];
			3'h4:    pre_hit = &div_q[2:0];
			3'h5:    pre_hit = &div_q[1:0];
			3'h6:    pre_hit = div_q[0];
			default: pre_hit = evt_q[2] & ~evt_q[1];
		endcase
	end

	assign tick = ce & pre_hit;
endmodule

// *** src/pin_driver.sv ***
// Timer output pin logic for toggle, force and PWM modes.
// Assumes ovf is a one-cycle pulse already qualified by the clock enable.
`timescale 1ns/1ps
module pin_driver (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic [2:0] mode,
	input  wire logic       ovf,
	input  wire logic [7:0] count,
	input  wire logic [7:0] load,
	output logic            pin_q,
	output logic            pin_owned
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
		end else if (ce) begin
			case (mode)
				// [R8] Overflow driven levels.
				timer_pkg::OUT_TOGGLE: if (ovf) pin_q <= ~pin_q;
				timer_pkg::OUT_FORCE0: if (ovf) pin_q <= 1'b0;
				timer_pkg::OUT_FORCE1: if (ovf) pin_q <= 1'b1;
				// [R10] Duty set by load value.
				timer_pkg::OUT_PWM:    pin_q <= (count >= load);
				default:               pin_q <= pin_q;
			endcase
		end
	end

	// [R7] Pin handed to the timer.
	assign pin_owned = (mode != timer_pkg::OUT_PORT);

	property p_force_high;
		@(posedge aclk) disable iff (!aresetn)
		(ce && ovf && mode == timer_pkg::OUT_FORCE1) |=> pin_q;
	endproperty
	a_force_high: assert property (p_force_high) else $error("force high missed"); // [R8]

	property p_toggle;
		@(posedge aclk) disable iff (!aresetn)
		(ce && ovf && mode == timer_pkg::OUT_TOGGLE) |=> pin_q != $past(pin_q);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed"); // [R8]
endmodule

// *** src/reload_timer.sv ***
// Eight-bit reload timer with watchdog, output pin and interrupt.
// Assumes an AXI4-Lite master on aclk and an asynchronous event pin.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module reload_timer (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	input  wire logic [7:0] awaddr,
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0] wstrb,
	input  wire logic       wvalid,
	output logic            wready,
	output logic [1:0]      bresp,
	output logic            bvalid,
	input  wire logic       bready,
	input  wire logic [7:0] araddr,
	input  wire logic       arvalid,
	output logic            arready,
	output logic [31:0]     rdata,
	output logic [1:0]      rresp,
	output logic            rvalid,
	input  wire logic       rready,
	input  wire logic       event_pin,
	output logic            timer_output_pin,
	output logic            timer_output_pin_oe,
	output logic            chip_reset_req,
	output logic            irq
);
	// ------------------------------------------------------------
	// Decode helpers.
	// ------------------------------------------------------------
	function automatic logic wr_mapped(input logic [5:0] idx);
		wr_mapped = (idx == timer_pkg::IDX_MODE_CLK) || (idx == timer_pkg::IDX_DIG_LOW) ||
			(idx == timer_pkg::IDX_DIG_HIGH) || (idx == timer_pkg::IDX_OUT_MODE) ||
			(idx == timer_pkg::IDX_WDOG) || (idx == timer_pkg::IDX_IRQ_CLR) ||
			(idx == timer_pkg::IDX_IRQ_EN);
	endfunction

	function automatic logic rd_mapped(input logic [5:0] idx);
		rd_mapped = (idx == timer_pkg::IDX_MODE_CLK) || (idx == timer_pkg::IDX_DIG_LOW) ||
			(idx == timer_pkg::IDX_DIG_HIGH) || (idx == timer_pkg::IDX_OUT_MODE) ||
			(idx == timer_pkg::IDX_WDOG) || (idx == timer_pkg::IDX_IRQ_STAT) ||
			(idx == timer_pkg::IDX_IRQ_EN) || (idx == timer_pkg::IDX_IRQ_CLR);
	endfunction

	logic [5:0]  aw_idx_q;
	logic        aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_have_q;
	logic        do_wr;
	logic        wr_en;
	logic        do_rd;
	logic [5:0]  rd_idx;
	logic [31:0] rd_d;

	logic [3:0]  mode_pend_q;
	logic        mode_pend_vld_q;
	logic [3:0]  mode_clk_q;
	logic [2:0]  out_mode_q;
	logic [3:0]  dig_low_q;
	logic [3:0]  dig_high_q;
	// [R18] Eight-bit counter.
	logic [7:0]  count_q;
	logic [3:0]  low_latch_q;
	logic        wdog_en_q;
	logic [7:0]  irq_stat_q;
	logic [7:0]  irq_en_q;
	logic        tick;
	logic        ovf;
	logic        wr_low;
	logic        wr_high;
	logic        pin_q;
	logic        pin_owned;

	// ------------------------------------------------------------
	// AXI4-Lite write channel.
	// ------------------------------------------------------------
	assign awready = ce & ~aw_have_q & ~bvalid;
	assign wready  = ce & ~w_have_q & ~bvalid;
	assign do_wr   = ce & aw_have_q & w_have_q & ~bvalid;
	assign wr_en   = do_wr & w_strb_q[0] & wr_mapped(aw_idx_q);
	assign wr_low  = wr_en && (aw_idx_q == timer_pkg::IDX_DIG_LOW);
	assign wr_high = wr_en && (aw_idx_q == timer_pkg::IDX_DIG_HIGH);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_idx_q  <= 6'h00;
		end else if (awvalid && awready) begin
			aw_have_q <= 1'b1;
			aw_idx_q  <= awaddr[7:2];
		end else if (do_wr) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_wr) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= timer_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp  <= wr_mapped(aw_idx_q) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_DECERR;
		end else if (ce && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel.
	// ------------------------------------------------------------
	assign arready = ce & ~rvalid;
	assign do_rd   = arvalid & arready;
	assign rd_idx  = araddr[7:2];

	always_comb begin
		rd_d = 32'h0000_0000;
		if (rd_idx == timer_pkg::IDX_DIG_HIGH) begin
			rd_d[3:0] = count_q[7:4];
		end else if (rd_idx == timer_pkg::IDX_DIG_LOW) begin
			rd_d[3:0] = low_latch_q;
		end else if (rd_idx == timer_pkg::IDX_OUT_MODE) begin
			rd_d[2:0] = out_mode_q;
		end else if (rd_idx == timer_pkg::IDX_WDOG) begin
			rd_d[timer_pkg::WDOG_BIT] = wdog_en_q;
		end else if (rd_idx == timer_pkg::IDX_IRQ_STAT) begin
			rd_d[7:0] = irq_stat_q;
		end else if (rd_idx == timer_pkg::IDX_IRQ_EN) begin
			rd_d[7:0] = irq_en_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= timer_pkg::RESP_OKAY;
		end else if (do_rd) begin
			rvalid <= 1'b1;
			rdata  <= rd_d;
			rresp  <= rd_mapped(rd_idx) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_DECERR;
		end else if (ce && rready) begin
			rvalid <= 1'b0;
		end
	end

	// [R16] Latch low digit on high read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_latch_q <= 4'h0;
		end else if (do_rd && rd_idx == timer_pkg::IDX_DIG_HIGH) begin
			low_latch_q <= count_q[3:0];
		end
	end

	// ------------------------------------------------------------
	// Control registers.
	// ------------------------------------------------------------
	// [R11] Delayed mode commit.
	// The staging flop keeps a new divider from cutting a tick in half mid-write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_pend_q     <= timer_pkg::MODE_CLK_RST;
			mode_pend_vld_q <= 1'b0;
			mode_clk_q      <= timer_pkg::MODE_CLK_RST;
		end else if (ce) begin
			mode_pend_vld_q <= wr_en && (aw_idx_q == timer_pkg::IDX_MODE_CLK);
			if (wr_en && aw_idx_q == timer_pkg::IDX_MODE_CLK) begin
				mode_pend_q <= w_data_q[3:0];
			end
			// [R1] Mode register update.
			if (mode_pend_vld_q) begin
				mode_clk_q <= mode_pend_q;
			end
		end
	end

	// [R12] Output mode register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_mode_q <= timer_pkg::OUT_MODE_RST;
		end else if (wr_en && aw_idx_q == timer_pkg::IDX_OUT_MODE) begin
			out_mode_q <= w_data_q[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_en_q <= 1'b0;
			irq_en_q  <= 8'h00;
		end else if (wr_en) begin
			if (aw_idx_q == timer_pkg::IDX_WDOG) begin
				wdog_en_q <= w_data_q[timer_pkg::WDOG_BIT];
			end
			if (aw_idx_q == timer_pkg::IDX_IRQ_EN) begin
				irq_en_q <= w_data_q[7:0];
			end
		end
	end

	// [R15] Load digit reset values.
	// The high digit has no meaningful reset value; zero only keeps simulation clean.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dig_low_q  <= timer_pkg::DIG_LOW_RST;
			dig_high_q <= 4'h0;
		end else begin
			// [R13] Low digit alone.
			if (wr_low) begin
				dig_low_q <= w_data_q[3:0];
			end
			if (wr_high) begin
				dig_high_q <= w_data_q[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Counter.
	// ------------------------------------------------------------
	tick_source u_tick (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.clk_sel   (mode_clk_q[2:0]),
		.event_pin (event_pin),
		.tick      (tick)
	);

	// [R3] Overflow at maximum count.
	assign ovf = tick && (count_q == timer_pkg::COUNT_MAX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= 8'h00;
		end else if (wr_high) begin
			// [R14] High digit loads counter.
			count_q <= {w_data_q[3:0], dig_low_q};
		end else if (ovf) begin
			// [R3] Reload or wrap.
			count_q <= mode_clk_q[timer_pkg::RELOAD_BIT] ? {dig_high_q, dig_low_q} : 8'h00;
		end else if (tick) begin
			// [R2] Count one per tick.
			count_q <= count_q + 8'h01;
		end
	end

	// [R5] Watchdog reset request.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_reset_req <= 1'b0;
		end else if (ce) begin
			chip_reset_req <= ovf & wdog_en_q;
		end
	end

	// ------------------------------------------------------------
	// Interrupt.
	// ------------------------------------------------------------
	// [R4] Sticky overflow flag, set wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 8'h00;
		end else begin
			if (wr_en && aw_idx_q == timer_pkg::IDX_IRQ_CLR) begin
				irq_stat_q <= irq_stat_q & ~w_data_q[7:0];
			end
			if (ovf) begin
				irq_stat_q[timer_pkg::OVF_BIT] <= 1'b1;
			end
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// ------------------------------------------------------------
	// Output pin.
	// ------------------------------------------------------------
	pin_driver u_pin (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.mode      (out_mode_q),
		.ovf       (ovf),
		.count     (count_q),
		.load      ({dig_high_q, dig_low_q}),
		.pin_q     (pin_q),
		.pin_owned (pin_owned)
	);

	assign timer_output_pin    = pin_q;
	assign timer_output_pin_oe = pin_owned;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	property p_count_step;
		@(posedge aclk) disable iff (!aresetn)
		(tick && !wr_high && count_q != timer_pkg::COUNT_MAX) |=> count_q == $past(count_q) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step"); // [R2]

	property p_reload;
		@(posedge aclk) disable iff (!aresetn)
		(ovf && !wr_high && mode_clk_q[timer_pkg::RELOAD_BIT]) |=> count_q == $past({dig_high_q, dig_low_q});
	endproperty
	a_reload: assert property (p_reload) else $error("reload value wrong"); // [R3]

	property p_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(ovf && !wr_high && !mode_clk_q[timer_pkg::RELOAD_BIT]) |=> count_q == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("free run did not wrap"); // [R3]

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		ovf |=> irq_stat_q[timer_pkg::OVF_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("overflow flag not set"); // [R4]

	property p_wdog;
		@(posedge aclk) disable iff (!aresetn)
		(ovf && wdog_en_q) |=> chip_reset_req;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset missing"); // [R5]

	property p_mode_delay;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_en && aw_idx_q == timer_pkg::IDX_MODE_CLK ##1 ce) |=> mode_clk_q == $past(w_data_q[3:0], 2);
	endproperty
	a_mode_delay: assert property (p_mode_delay) else $error("mode commit late"); // [R11]

	property p_low_only;
		@(posedge aclk) disable iff (!aresetn)
		(wr_low && !tick) |=> count_q == $past(count_q);
	endproperty
	a_low_only: assert property (p_low_only) else $error("low digit moved counter"); // [R13]

	property p_high_load;
		@(posedge aclk) disable iff (!aresetn)
		wr_high |=> count_q == {dig_high_q, dig_low_q};
	endproperty
	a_high_load: assert property (p_high_load) else $error("high digit load wrong"); // [R14]

	property p_latch;
		@(posedge aclk) disable iff (!aresetn)
		(do_rd && rd_idx == timer_pkg::IDX_DIG_HIGH) |=> low_latch_q == $past(count_q[3:0]);
	endproperty
	a_latch: assert property (p_latch) else $error("low digit not latched"); // [R16]
endmodule

// *** dv/reload_timer_test.sv ***
// Self-checking bench for the reload timer, driving every port directly.
// Assumes the AXI4-Lite slave of reload_timer and the event pin as the tick source.
`timescale 1ns/1ps
module reload_timer_test;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic        aclk, aresetn, ce, event_pin;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	logic        timer_output_pin, timer_output_pin_oe, chip_reset_req, irq;
	logic [7:0]  cnt, ld, got;
	logic        pin, rl;
	int          bad_count, samples_checked, pulses, ovf, om, i, p0;

	reload_timer reload_timer_i (
		.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.event_pin, .timer_output_pin, .timer_output_pin_oe, .chip_reset_req, .irq
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (chip_reset_req === 1'b1) pulses++;
	end

	// ----------------------------------------
	// Tasks and expectation functions
	// ----------------------------------------
	task automatic end_of_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		int n;
		awaddr  <= {ix, 2'b00};
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		rsp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
		if (n == 40) begin
			chk("write_timeout", 32'h0, 32'h1);
			end_of_test();
		end
	endtask

	task automatic rd(input logic [5:0] ix);
		int n;
		araddr  <= {ix, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rd_d = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (n == 40) begin
			chk("read_timeout", 32'h0, 32'h1);
			end_of_test();
		end
	endtask

	// Upper digit first, so the lower digit comes from the latch.
	task automatic rdcnt(output logic [7:0] c);
		rd(timer_pkg::IDX_DIG_HIGH);
		c[7:4] = rd_d[3:0];
		rd(timer_pkg::IDX_DIG_LOW);
		c[3:0] = rd_d[3:0];
	endtask

	task automatic load(input logic [7:0] v);
		wr(timer_pkg::IDX_DIG_LOW, {28'h0, v[3:0]});
		wr(timer_pkg::IDX_DIG_HIGH, {28'h0, v[7:4]});
		cnt = v;
		ld = v;
	endtask

	function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] l, input logic r);
		return (c == timer_pkg::COUNT_MAX) ? (r ? l : 8'h00) : c + 8'h01;
	endfunction

	// Each falling edge of the event pin is one tick; levels last long enough for the synchroniser.
	task automatic tick(input int n);
		repeat (n) begin
			event_pin <= 1'b0;
			repeat (4) @(posedge aclk);
			event_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			if (cnt == timer_pkg::COUNT_MAX) begin
				ovf++;
				if (om == 1) pin = ~pin;
				if (om == 2) pin = 1'b0;
				if (om == 3) pin = 1'b1;
			end
			cnt = nxt(cnt, ld, rl);
		end
	endtask

	initial begin
		repeat (100000) @(posedge aclk);
		chk("run_timeout", 32'h0, 32'h1);
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{ce, event_pin} = 2'h3;
		{awaddr, araddr, wdata, wstrb} = '0;
		{pin, rl, om} = '0;
		void'($urandom(81));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("pin_oe", 32'h0, timer_output_pin_oe);
		chk("pin", 32'h0, timer_output_pin);
		rd(timer_pkg::IDX_OUT_MODE);
		chk("out_mode", 32'h0, rd_d & 32'h7);
		chk("out_mode_resp", timer_pkg::RESP_OKAY, rsp);
		rd(timer_pkg::IDX_IRQ_STAT);
		chk("status", 32'h0, rd_d & 32'h4);
		rd(6'h3f);
		chk("unmapped_resp", timer_pkg::RESP_DECERR, rsp);
		chk("unmapped_data", 32'h0, rd_d);
		wr(6'h3f, 32'h5);
		chk("unmapped_bresp", timer_pkg::RESP_DECERR, rsp);
		wr(timer_pkg::IDX_MODE_CLK, {28'h0, 1'b0, timer_pkg::CLK_EXT});
		chk("mode_bresp", timer_pkg::RESP_OKAY, rsp);
		repeat (2) @(posedge aclk);
		// Upper digit alone loads over the reset lower digit.
		wr(timer_pkg::IDX_DIG_HIGH, 32'h5);
		rdcnt(got);
		chk("count", 32'h50, got);
		ld = 8'($urandom_range(255, 0));
		wr(timer_pkg::IDX_DIG_LOW, {28'h0, ld[3:0]});
		rdcnt(got);
		chk("count", 32'h50, got);
		wr(timer_pkg::IDX_DIG_HIGH, {28'h0, ld[7:4]});
		rdcnt(got);
		chk("count", ld, got);
		om = 1;
		wr(timer_pkg::IDX_OUT_MODE, 32'h1);
		chk("pin_oe", 32'h1, timer_output_pin_oe);
		for (i = 0; i < 5; i++) begin
			rl = 1'($urandom_range(1, 0));
			wr(timer_pkg::IDX_MODE_CLK, {28'h0, rl, timer_pkg::CLK_EXT});
			repeat (2) @(posedge aclk);
			load(8'hf8 + 8'($urandom_range(7, 0)));
			ovf = 0;
			tick($urandom_range(12, 1));
			rdcnt(got);
			chk("count", cnt, got);
			rd(timer_pkg::IDX_IRQ_STAT);
			chk("status", (ovf > 0) ? 32'h4 : 32'h0, rd_d & 32'h4);
			chk("pin", pin, timer_output_pin);
			wr(timer_pkg::IDX_IRQ_CLR, 32'h4);
		end
		load(8'h3e);
		rd(timer_pkg::IDX_DIG_HIGH);
		chk("count_high", 32'h3, rd_d & 32'hf);
		tick(1);
		rd(timer_pkg::IDX_DIG_LOW);
		chk("count_low", 32'he, rd_d & 32'hf);
		// Each force mode is chosen only against the opposite present level.
		for (i = 0; i < 2; i++) begin
			om = pin ? 2 : 3;
			wr(timer_pkg::IDX_OUT_MODE, om);
			load(8'hff);
			tick(1);
			chk("pin", pin, timer_output_pin);
		end
		wr(timer_pkg::IDX_IRQ_CLR, 32'h4);
		wr(timer_pkg::IDX_IRQ_EN, 32'h4);
		chk("irq", 32'h0, irq);
		load(8'hff);
		tick(1);
		chk("irq", 32'h1, irq);
		wr(timer_pkg::IDX_IRQ_EN, 32'h0);
		chk("irq", 32'h0, irq);
		wr(timer_pkg::IDX_IRQ_EN, 32'h4);
		chk("irq", 32'h1, irq);
		wr(timer_pkg::IDX_IRQ_CLR, 32'h4);
		chk("irq", 32'h0, irq);
		p0 = pulses;
		wr(timer_pkg::IDX_WDOG, 32'h2);
		for (i = 0; i < 3; i++) begin
			load(8'hfe);
			tick(1);
		end
		chk("wdog_pulses", p0, pulses);
		load(8'hff);
		tick(1);
		chk("wdog_pulses", p0 + 1, pulses);
		wr(timer_pkg::IDX_WDOG, 32'h0);
		load(8'hff);
		tick(1);
		chk("wdog_pulses", p0 + 1, pulses);
		// With the clock enable low an event edge is lost and the bus is refused.
		load(8'h20);
		ce <= 1'b0;
		event_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("ready_ce_low", 32'h0, {awready, wready, arready});
		event_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		ce <= 1'b1;
		rdcnt(got);
		chk("count_ce_low", 32'h20, got);
		// PWM duty is taken as count at or above the load value.
		om = 4;
		wr(timer_pkg::IDX_OUT_MODE, 32'h4);
		load(8'h80);
		repeat (2) @(posedge aclk);
		chk("pwm_pin", 32'h1, timer_output_pin);
		wr(timer_pkg::IDX_DIG_LOW, 32'hf);
		repeat (2) @(posedge aclk);
		chk("pwm_pin", 32'h0, timer_output_pin);
		rd(timer_pkg::IDX_OUT_MODE);
		chk("out_mode", 32'h4, rd_d & 32'h7);
		wr(timer_pkg::IDX_OUT_MODE, 32'h0);
		chk("pin_oe", 32'h0, timer_output_pin_oe);
		end_of_test();
	end
endmodule
